// *** design/psu_fault_params.svh ***
`ifndef PSU_FAULT_PARAMS_SVH
`define PSU_FAULT_PARAMS_SVH

// timing
`define CLK_HZ          10000000
`define BLINK_HALF_MS   500
`define BLINK_HALF_CYC  (`CLK_HZ / 1000 * `BLINK_HALF_MS)
`define SETTLE_MS       10
`define SETTLE_CYC      (`CLK_HZ / 1000 * `SETTLE_MS)
`define ADDR_HOLD_S     15
`define ADDR_HOLD_CYC   (`CLK_HZ * `ADDR_HOLD_S)

// test-function data byte
`define TEST_BYTE_IDLE  8'h00
`define TEST_BYTE_LED   8'h01
`define TEST_BYTE_ORING 8'h10
`define TEST_BYTE_BOTH  8'h11
`define TEST_LED_BIT    0
`define TEST_ORING_BIT  4

// status word: [15:8] status-2, [7:0] status-1
`define ST_OUTPUT_ON    0
`define ST_LED_TEST     1
`define ST_EXT_FAULT    2
`define ST_SHUTDOWN     4
`define ST_INT_FAULT    5
`define ST_ISO_OK       6
`define ST_REMOTE_ON    8
`define ST_ISO_FAIL     11
`define ST_INVALID      13
`define STATUS_RAW_MASK 16'hDE40
`define STATUS_RESET    16'h0000

// alarm word: [15:8] alarm-2, [7:0] alarm-1
`define ALARM_EXT_MASK  16'h0009
`define ALARM_SHUT_MASK 16'hF064
`define ALARM_INFO_MASK 16'h0F92
`define ALARM_RESET     16'h0000

`define FAN_TOL_PCT     20
// upper address nibble: arbitrary value
`define ADDR_UPPER      4'hB

`endif

// *** design/psu_fault_pkg.sv ***
`include "psu_fault_params.svh"

package psu_fault_pkg;

  typedef enum logic [1:0]
  {
    CMD_NONE   = 2'b00,
    CMD_CLEAR  = 2'b01,
    CMD_OUTPUT = 2'b10,
    CMD_TEST   = 2'b11
  } cmd_kind_type;

  typedef enum logic [1:0]
  {
    H_IDLE     = 2'b00,
    H_HOLD     = 2'b01,
    H_ISO_WAIT = 2'b10
  } host_state_type;

  typedef logic [2:0][15:0] fan_rpm_type;

  function automatic logic test_byte_ok(input logic [7:0] b);
  begin
    return (b == `TEST_BYTE_IDLE) || (b == `TEST_BYTE_LED) ||
           (b == `TEST_BYTE_ORING) || (b == `TEST_BYTE_BOTH);
  end
  endfunction : test_byte_ok

endpackage : psu_fault_pkg

// *** design/psu_link_if.sv ***
`timescale 1ns/10ps

interface psu_link_if;
  import psu_fault_pkg::*;

  logic         alert_n;
  logic         present;
  logic [6:0]   dev_addr;
  logic [15:0]  status_word;
  logic [15:0]  alarm_word;
  cmd_kind_type cmd_kind;
  logic [7:0]   cmd_data;

  modport device
  (
    output alert_n,
    output present,
    output dev_addr,
    output status_word,
    output alarm_word,
    input  cmd_kind,
    input  cmd_data
  );

  modport host
  (
    input  alert_n,
    input  present,
    input  dev_addr,
    input  status_word,
    input  alarm_word,
    output cmd_kind,
    output cmd_data
  );
endinterface : psu_link_if

// *** design/blink_timer.sv ***
`timescale 1ns/10ps
`include "psu_fault_params.svh"

module blink_timer
#(
  parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
)
(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  output logic      phase_o,
  output logic      wrap_o
);

  logic [22:0] cnt_reg;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg <= 23'h000000;
      phase_o <= 1'b0;
      wrap_o  <= 1'b0;
    end
    else if (cnt_reg == 23'(HALF_CYC - 1))
    begin
      cnt_reg <= 23'h000000;
      phase_o <= ~phase_o;
      wrap_o  <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 23'h000001;
      wrap_o  <= 1'b0;
    end
  end

endmodule : blink_timer

// *** design/psu_fault_alert_manager.sv ***
`timescale 1ns/10ps
`include "psu_fault_params.svh"

// What this block does
// - host sends only 00, 01, 10, 11 test bytes
// - latch status only after conditions settle
// - settled change raises alert, holds until clear
// - later changes accumulate onto held contents
// - external faults never drive fault indications
// - input lamp blinks out of range, dark absent
// - power-up raises a state change
// - hot insertion raises a state change
// - status or alarm changes not caused by the host raise alert
// - host-caused changes update without alert
// - default address low bits zero for 15s
// - host stops traffic 15s after new unit
// - host judges isolation test, ensures capacity
// - fan speeds over 20% apart warn wear
// - information-only alarms never cause shutdown
// - input lamp green when input in limits
// - output lamp green, blinking or red
// - blink half second on, half off
module psu_fault_alert_manager
#(
  parameter int unsigned SETTLE_CYC    = `SETTLE_CYC,
  parameter int unsigned ADDR_HOLD_CYC = `ADDR_HOLD_CYC,
  parameter int unsigned BLINK_CYC     = `BLINK_HALF_CYC
)
(
  input  wire logic                      clock_i,
  input  wire logic                      resetn_i,
  psu_link_if.device                     link,
  input  wire logic [15:0]               alarm_raw_i,
  input  wire logic [15:0]               status_raw_i,
  input  wire psu_fault_pkg::fan_rpm_type fan_rpm_i,
  input  wire logic [2:0]                fan_fitted_i,
  input  wire logic [2:0]                addr_pins_i,
  input  wire logic                      remote_on_i,
  input  wire logic                      input_present_i,
  input  wire logic                      input_in_range_i,
  input  wire logic                      output_present_i,
  input  wire logic                      mated_i,
  output logic                           output_enable_o,
  output logic                           oring_test_o,
  output logic                           fault_pin_o,
  output logic                           shutdown_o,
  output logic                           fan_wear_o,
  output logic                           input_good_lamp_o,
  output logic                           output_fault_lamp_green_o,
  output logic                           output_fault_lamp_red_o
);
  import psu_fault_pkg::*;

  localparam int SYNC_W = 91;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [15:0]       alarm_s;
  logic [15:0]       status_s;
  fan_rpm_type       fan_s;
  logic [2:0]        fitted_s;
  logic [2:0]        pins_s;
  logic              remote_s;
  logic              in_pres_s;
  logic              in_range_s;
  logic              out_pres_s;
  logic              mated_s;
  logic              mated_prev_reg;
  logic              hot_plug;
  logic              fan_wear;
  logic              int_fault;
  logic              shutdown;
  logic [15:0]       obs_status;
  logic [15:0]       obs_alarm;
  logic [32:0]       obs_now;
  logic [32:0]       obs_prev_reg;
  logic [32:0]       snap_reg;
  logic [16:0]       settle_cnt_reg;
  logic              stable;
  logic              evt;
  logic              evt_alert;
  logic              keep;
  logic              clear_cmd;
  logic              pending_reg;
  logic              host_cause_reg;
  logic              alert_n_reg;
  logic [15:0]       status_word_reg;
  logic [15:0]       alarm_word_reg;
  logic              led_test_reg;
  logic              invalid_reg;
  logic [27:0]       addr_cnt_reg;
  logic [6:0]        dev_addr_reg;
  logic              present_reg;
  logic              phase;
  logic              wrap;
  logic [1:0]        color_reg;

  function automatic logic fans_apart(input logic [15:0] a,
                                      input logic [15:0] b);
    logic [23:0] lo;
    logic [23:0] hi;
  begin
    lo = 24'((a < b) ? a : b) * 24'd100;
    hi = 24'((a < b) ? b : a) * 24'(100 - `FAN_TOL_PCT);
    return lo < hi;
  end
  endfunction : fans_apart

  // every pin input passes two flops before use
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {alarm_raw_i, status_raw_i, fan_rpm_i, fan_fitted_i,
                    addr_pins_i, remote_on_i, input_present_i,
                    input_in_range_i, output_present_i, mated_i};
      sync2_reg <= sync1_reg;
    end
  end

  assign {alarm_s, status_s, fan_s, fitted_s, pins_s, remote_s, in_pres_s,
          in_range_s, out_pres_s, mated_s} = sync2_reg;

  assign fan_wear = (fitted_s[0] && fitted_s[1] && fans_apart(fan_s[0], fan_s[1]))
    || (fitted_s[0] && fitted_s[2] && fans_apart(fan_s[0], fan_s[2]))
    || (fitted_s[1] && fitted_s[2] && fans_apart(fan_s[1], fan_s[2]));
  assign int_fault = |(alarm_s & ~`ALARM_EXT_MASK);
  assign shutdown  = |(alarm_s & `ALARM_SHUT_MASK);
  assign hot_plug  = mated_s && !mated_prev_reg;

  always_comb
  begin
    obs_status                = status_s & `STATUS_RAW_MASK;
    obs_status[`ST_OUTPUT_ON] = out_pres_s;
    obs_status[`ST_LED_TEST]  = led_test_reg;
    obs_status[`ST_EXT_FAULT] = |(alarm_s & `ALARM_EXT_MASK);
    obs_status[`ST_SHUTDOWN]  = shutdown;
    obs_status[`ST_INT_FAULT] = int_fault;
    obs_status[`ST_REMOTE_ON] = remote_s;
    obs_status[`ST_INVALID]   = invalid_reg;
  end

  // external faults stay out of the bus alarm word
  assign obs_alarm = alarm_s & ~`ALARM_EXT_MASK;
  assign obs_now   = {fan_wear, obs_status, obs_alarm};

  // transitional states restart the settle window
  assign stable    = (settle_cnt_reg == 17'(SETTLE_CYC - 1)) &&
                     (obs_now == obs_prev_reg);
  assign evt       = stable && ((obs_prev_reg != snap_reg) || pending_reg);
  assign evt_alert = evt && (!host_cause_reg || pending_reg);
  assign clear_cmd = (link.cmd_kind == CMD_CLEAR);
  assign keep      = !alert_n_reg && !clear_cmd;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      obs_prev_reg   <= '0;
      settle_cnt_reg <= 17'h00000;
      snap_reg       <= '0;
    end
    else
    begin
      obs_prev_reg <= obs_now;
      if (obs_now != obs_prev_reg)
        settle_cnt_reg <= 17'h00000;
      else if (settle_cnt_reg != 17'(SETTLE_CYC - 1))
        settle_cnt_reg <= settle_cnt_reg + 17'h00001;
      if (evt)
        snap_reg <= obs_prev_reg;
    end
  end

  // power-up and insertion both count as a state change
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pending_reg    <= 1'b1;
      mated_prev_reg <= 1'b0;
      present_reg    <= 1'b0;
    end
    else
    begin
      mated_prev_reg <= mated_s;
      present_reg    <= mated_s;
      if (hot_plug)
        pending_reg <= 1'b1;
      else if (evt)
        pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      host_cause_reg <= 1'b0;
    else if (link.cmd_kind == CMD_OUTPUT || link.cmd_kind == CMD_TEST)
      host_cause_reg <= 1'b1;
    else if (evt)
      host_cause_reg <= 1'b0;  // a no-op command masks the next event
  end

  // a new event in the clear cycle keeps the alert up
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      alert_n_reg <= 1'b1;
    else if (evt_alert)
      alert_n_reg <= 1'b0;
    else if (clear_cmd)
      alert_n_reg <= 1'b1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      status_word_reg <= `STATUS_RESET;
      alarm_word_reg  <= `ALARM_RESET;
    end
    else if (evt && keep)
    begin
      status_word_reg <= status_word_reg | obs_prev_reg[31:16];
      alarm_word_reg  <= alarm_word_reg | obs_prev_reg[15:0];
    end
    else if (evt)
      {status_word_reg, alarm_word_reg} <= obs_prev_reg[31:0];
    else if (clear_cmd)
      {status_word_reg, alarm_word_reg} <= snap_reg[31:0];
  end

  // invalid bytes are flagged, never acted on
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      output_enable_o <= 1'b1;
      led_test_reg    <= 1'b0;
      oring_test_o    <= 1'b0;
      invalid_reg     <= 1'b0;
    end
    else if (link.cmd_kind == CMD_OUTPUT)
      output_enable_o <= link.cmd_data[0];
    else if (link.cmd_kind == CMD_TEST && test_byte_ok(link.cmd_data))
    begin
      led_test_reg <= link.cmd_data[`TEST_LED_BIT];
      oring_test_o <= link.cmd_data[`TEST_ORING_BIT];
    end
    else if (link.cmd_kind == CMD_TEST)
      invalid_reg <= 1'b1;
    else if (clear_cmd)
      invalid_reg <= 1'b0;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      addr_cnt_reg <= 28'(ADDR_HOLD_CYC - 1);
      dev_addr_reg <= {`ADDR_UPPER, 3'b000};
    end
    else
    begin
      if (hot_plug)
        addr_cnt_reg <= 28'(ADDR_HOLD_CYC - 1);
      else if (addr_cnt_reg != 28'h0000000)
        addr_cnt_reg <= addr_cnt_reg - 28'h0000001;
      dev_addr_reg <= {`ADDR_UPPER,
                       (addr_cnt_reg == 28'h0000000 && !hot_plug) ?
                       pins_s : 3'b000};
    end
  end

  blink_timer #(.HALF_CYC(BLINK_CYC)) u_blink
  (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .phase_o  (phase),
    .wrap_o   (wrap)
  );

  // lamp test walks green, orange, red
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      color_reg <= 2'h0;
    else if (!led_test_reg)
      color_reg <= 2'h0;
    else if (wrap && phase)
      color_reg <= (color_reg == 2'h2) ? 2'h0 : color_reg + 2'h1;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      input_good_lamp_o         <= 1'b0;
      output_fault_lamp_green_o <= 1'b0;
      output_fault_lamp_red_o   <= 1'b0;
      fault_pin_o               <= 1'b0;
      shutdown_o                <= 1'b0;
      fan_wear_o                <= 1'b0;
    end
    else
    begin
      fault_pin_o <= int_fault;
      shutdown_o  <= shutdown;
      fan_wear_o  <= fan_wear;
      if (led_test_reg)
      begin
        input_good_lamp_o         <= phase;
        output_fault_lamp_green_o <= phase && (color_reg != 2'h2);
        output_fault_lamp_red_o   <= phase && (color_reg != 2'h0);
      end
      else
      begin
        input_good_lamp_o <= in_range_s || (in_pres_s && phase);
        output_fault_lamp_red_o   <= shutdown;
        output_fault_lamp_green_o <= !shutdown && out_pres_s &&
                                     (!int_fault || phase);
      end
    end
  end

  assign link.alert_n     = alert_n_reg;
  assign link.present     = present_reg;
  assign link.dev_addr    = dev_addr_reg;
  assign link.status_word = status_word_reg;
  assign link.alarm_word  = alarm_word_reg;

endmodule : psu_fault_alert_manager

// *** design/system_controller_end.sv ***
`timescale 1ns/10ps
`include "psu_fault_params.svh"

module system_controller_end
#(
  parameter int unsigned ADDR_HOLD_CYC = `ADDR_HOLD_CYC
)
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  psu_link_if.host         link,
  input  wire logic        clear_req_i,
  input  wire logic        output_req_i,
  input  wire logic        output_on_i,
  input  wire logic        test_req_i,
  input  wire logic [7:0]  test_byte_i,
  input  wire logic        capacity_ok_i,
  output logic             cmd_reject_o,
  output logic             alert_seen_o,
  output logic             bus_hold_o,
  output logic             iso_done_o,
  output logic             iso_pass_o,
  output logic [15:0]      status_o,
  output logic [15:0]      alarm_o
);
  import psu_fault_pkg::*;

  host_state_type state_reg;
  host_state_type state_next;
  cmd_kind_type   kind_reg;
  cmd_kind_type   kind_next;
  logic [7:0]     data_reg;
  logic [7:0]     data_next;
  logic           reject_next;
  logic           present_prev_reg;
  logic           new_unit;
  logic [27:0]    hold_cnt_reg;
  logic           iso_seen;
  logic           oring_ask;

  assign new_unit  = link.present && !present_prev_reg;
  assign iso_seen  = link.status_word[`ST_ISO_OK] ||
                     link.status_word[`ST_ISO_FAIL];
  assign oring_ask = test_byte_i[`TEST_ORING_BIT];

  // one request per cycle: clear, then output, then test
  always_comb
  begin
    kind_next   = CMD_NONE;
    data_next   = 8'h00;
    reject_next = 1'b0;
    if (new_unit || state_reg == H_HOLD)
      reject_next = clear_req_i || output_req_i || test_req_i;
    else if (clear_req_i)
    begin
      kind_next   = CMD_CLEAR;
      reject_next = output_req_i || test_req_i;
    end
    else if (output_req_i)
    begin
      kind_next   = CMD_OUTPUT;
      data_next   = {7'h00, output_on_i};
      reject_next = test_req_i;
    end
    else if (test_req_i && test_byte_ok(test_byte_i) &&
             (!oring_ask || (capacity_ok_i && state_reg == H_IDLE)))
    begin
      kind_next = CMD_TEST;
      data_next = test_byte_i;
    end
    else
      reject_next = test_req_i;
  end

  always_comb
  begin
    state_next = state_reg;
    if (new_unit)
      state_next = H_HOLD;
    else
    begin
      unique case (state_reg)
        H_IDLE:
          if (kind_next == CMD_TEST && oring_ask)
            state_next = H_ISO_WAIT;
        H_HOLD:
          if (hold_cnt_reg == 28'h0000000)
            state_next = H_IDLE;
        H_ISO_WAIT:
          if (iso_seen)
            state_next = H_IDLE;
        default:
          state_next = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg        <= H_IDLE;
      present_prev_reg <= 1'b0;
      hold_cnt_reg     <= 28'h0000000;
    end
    else
    begin
      state_reg        <= state_next;
      present_prev_reg <= link.present;
      if (new_unit)
        hold_cnt_reg <= 28'(ADDR_HOLD_CYC - 1);
      else if (hold_cnt_reg != 28'h0000000)
        hold_cnt_reg <= hold_cnt_reg - 28'h0000001;
    end
  end

  // the unit reports raw results; pass or fail is decided here
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      iso_done_o <= 1'b0;
      iso_pass_o <= 1'b0;
    end
    else
    begin
      iso_done_o <= (state_reg == H_ISO_WAIT) && iso_seen && !new_unit;
      if ((state_reg == H_ISO_WAIT) && iso_seen && !new_unit)
        iso_pass_o <= link.status_word[`ST_ISO_OK] &&
                      !link.status_word[`ST_ISO_FAIL];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      kind_reg     <= CMD_NONE;
      data_reg     <= 8'h00;
      cmd_reject_o <= 1'b0;
      alert_seen_o <= 1'b0;
      bus_hold_o   <= 1'b0;
      status_o     <= 16'h0000;
      alarm_o      <= 16'h0000;
    end
    else
    begin
      kind_reg     <= kind_next;
      data_reg     <= data_next;
      cmd_reject_o <= reject_next;
      alert_seen_o <= !link.alert_n;
      bus_hold_o   <= (state_next == H_HOLD);
      status_o     <= link.status_word;
      alarm_o      <= link.alarm_word;
    end
  end

  assign link.cmd_kind = kind_reg;
  assign link.cmd_data = data_reg;

endmodule : system_controller_end

// *** tb/psu_fault_props.sv ***
`timescale 1ns/10ps
`include "psu_fault_params.svh"

module psu_fault_props
  import psu_fault_pkg::*;
#(
  parameter int unsigned ADDR_HOLD_CYC = 20
)
(
  input wire logic         clock_i,
  input wire logic         resetn_i,
  input wire logic         alert_n,
  input wire logic         present,
  input wire logic [6:0]   dev_addr,
  input wire logic [15:0]  status_word,
  input wire logic [15:0]  alarm_word,
  input wire cmd_kind_type cmd_kind,
  input wire logic [7:0]   cmd_data
);
  int unsigned cnt;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // cycles online, saturating so it never wraps
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt <= 0;
    else
      cnt <= !present ? 0 : (cnt < ADDR_HOLD_CYC ? cnt + 1 : cnt);
  end

  sequence s_latched;
    !alert_n && cmd_kind != CMD_CLEAR;
  endsequence

  // two sync stages plus four settle cycles
  AST_RESET_QUIET: assert property ($rose(resetn_i) |-> alert_n[*6])
    else $error("alert before settle");
  AST_HOLD: assert property (s_latched |=> !alert_n)
    else $error("alert dropped without clear");
  AST_STATUS_ACCUM: assert property (s_latched |=>
    (status_word | $past(status_word)) == status_word)
    else $error("status bit lost while latched");
  AST_ALARM_ACCUM: assert property (s_latched |=>
    (alarm_word | $past(alarm_word)) == alarm_word)
    else $error("alarm bit lost while latched");
  AST_EXT_MASKED: assert property (alarm_word[0] == 1'b0 &&
    alarm_word[3] == 1'b0)
    else $error("external fault in alarm word");
  AST_TEST_DATA: assert property (cmd_kind == CMD_TEST |->
    cmd_data inside {8'h00, 8'h01, 8'h10, 8'h11})
    else $error("bad test byte sent");
  // margin of two cycles for where the device starts its count
  AST_ADDR_DEFAULT: assert property (present &&
    cnt < ADDR_HOLD_CYC - 2 |-> dev_addr[2:0] == 3'b000)
    else $error("address left default early");
  AST_ADDR_UPPER: assert property (dev_addr[6:3] == `ADDR_UPPER)
    else $error("upper address changed");
endmodule : psu_fault_props

// *** tb/tb.sv ***
`timescale 1ns/10ps
`include "psu_fault_params.svh"

module tb;
  import psu_fault_pkg::*;
  logic        clock_i = 0;
  logic        resetn_i = 0;
  logic [15:0] alarm_raw_i = 16'h0000;
  logic [15:0] status_raw_i = 16'h0000;
  fan_rpm_type fan_rpm_i = {3{16'h1000}};
  logic        in_range = 1;
  logic        in_pres = 1;
  logic        remote = 1, out_pres = 1, mated = 1;
  logic [2:0]  fitted = 3'h7, pins = 3'h5;
  logic        capacity_ok_i = 1;
  logic        clear_req_i = 0;
  logic        output_req_i = 0;
  logic        output_on_i = 1;
  logic        test_req_i = 0;
  logic [7:0]  test_byte_i = 8'h00;
  logic        out_en, oring, fault_pin, shut, wear, in_lamp, green, red;
  logic        rej_o, bus_hold_o, iso_done_o, iso_pass_o, seen;
  logic [15:0] st_o, al_o;
  logic        rej = 0;
  logic [7:0]  bytes [4] = '{8'h00, 8'h01, 8'h10, 8'h11};
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;

  always #50 clock_i = ~clock_i;

  psu_link_if psu_link_if_i ();

  psu_fault_alert_manager #(.SETTLE_CYC(4), .ADDR_HOLD_CYC(20), .BLINK_CYC(3))
    psu_fault_alert_manager_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .link(psu_link_if_i), .alarm_raw_i(alarm_raw_i),
    .status_raw_i(status_raw_i), .fan_rpm_i(fan_rpm_i),
    .fan_fitted_i(fitted), .addr_pins_i(pins), .remote_on_i(remote),
    .input_present_i(in_pres), .input_in_range_i(in_range),
    .output_present_i(out_pres), .mated_i(mated), .output_enable_o(out_en),
    .oring_test_o(oring), .fault_pin_o(fault_pin), .shutdown_o(shut),
    .fan_wear_o(wear), .input_good_lamp_o(in_lamp),
    .output_fault_lamp_green_o(green), .output_fault_lamp_red_o(red));

  system_controller_end #(.ADDR_HOLD_CYC(20)) system_controller_end_i
    (.clock_i(clock_i), .resetn_i(resetn_i), .link(psu_link_if_i),
    .clear_req_i(clear_req_i), .output_req_i(output_req_i),
    .output_on_i(output_on_i), .test_req_i(test_req_i),
    .test_byte_i(test_byte_i), .capacity_ok_i(capacity_ok_i),
    .cmd_reject_o(rej_o), .alert_seen_o(seen), .bus_hold_o(bus_hold_o),
    .iso_done_o(iso_done_o), .iso_pass_o(iso_pass_o), .status_o(st_o),
    .alarm_o(al_o));

  psu_fault_props #(.ADDR_HOLD_CYC(20)) psu_fault_props_i
    (.clock_i(clock_i), .resetn_i(resetn_i),
    .alert_n(psu_link_if_i.alert_n), .present(psu_link_if_i.present),
    .dev_addr(psu_link_if_i.dev_addr),
    .status_word(psu_link_if_i.status_word),
    .alarm_word(psu_link_if_i.alarm_word),
    .cmd_kind(psu_link_if_i.cmd_kind), .cmd_data(psu_link_if_i.cmd_data));

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // ends just past an edge so flop updates have landed
  task cyc_n(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc_n

  // w: bit0 clear, bit1 output, bit2 test; one-cycle request pulse
  task send(input logic [2:0] w, input logic [7:0] b);
    @(posedge clock_i);
    rej <= 0;
    clear_req_i <= w[0];
    output_req_i <= w[1];
    test_req_i <= w[2];
    test_byte_i <= b;
    output_on_i <= b[0];
    @(posedge clock_i);
    clear_req_i <= 0;
    output_req_i <= 0;
    test_req_i <= 0;
    cyc_n(3);
  endtask : send

  // 0: alert low, 1: hold over, 2: isolation done
  task wait_sig(input int sel);
    n = 0;
    while (n < 60 && !(sel == 0 ? psu_link_if_i.alert_n === 1'b0 :
           sel == 1 ? bus_hold_o === 1'b0 : iso_done_o === 1'b1))
    begin
      cyc_n(1);
      n++;
    end
  endtask : wait_sig

  // twelve cycles hold exactly two periods of a 3+3 cadence
  task blink(input logic lamp_sel, output int c);
    c = 0;
    repeat (12)
    begin
      cyc_n(1);
      c += ((lamp_sel ? green : in_lamp) === 1'b1);
    end
  endtask : blink

  always @(posedge clock_i)
  begin
    if (rej_o === 1'b1)
      rej <= 1;
    cyc <= cyc + 1;
    out_pres <= out_en;
    if (cyc == 3000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1;
    cyc_n(4);
    send(3'b001, 8'h00);
    chk("bus_hold", 1, bus_hold_o);
    chk("reject", 1, rej);
    chk("addr", {`ADDR_UPPER, 3'b000}, psu_link_if_i.dev_addr);
    wait_sig(0);
    chk("alert", 0, psu_link_if_i.alert_n);
    chk("present", 1, psu_link_if_i.present);
    chk("alert_seen", 1, seen);
    wait_sig(1);
    cyc_n(4);
    chk("addr", {`ADDR_UPPER, 3'b101}, psu_link_if_i.dev_addr);
    send(3'b001, 8'h00);
    chk("alert", 1, psu_link_if_i.alert_n);
    $display("test startup done");
    @(posedge clock_i);
    alarm_raw_i <= 16'h0002;
    repeat (2) @(posedge clock_i);
    alarm_raw_i <= 16'h0010;
    cyc_n(12);
    chk("alarm", 16'h0010, psu_link_if_i.alarm_word);
    chk("alarm_copy", 16'h0010, al_o);
    chk("alert", 0, psu_link_if_i.alert_n);
    chk("shutdown", 0, shut);
    chk("red", 0, red);
    blink(1, n);
    chk("green_blink", 6, n);
    @(posedge clock_i);
    alarm_raw_i <= 16'h8000;
    cyc_n(12);
    chk("alarm", 16'h8010, psu_link_if_i.alarm_word);
    chk("red", 1, red);
    send(3'b001, 8'h00);
    chk("alert", 1, psu_link_if_i.alert_n);
    chk("alarm", 16'h8000, psu_link_if_i.alarm_word);
    @(posedge clock_i);
    alarm_raw_i <= 16'h0009;
    cyc_n(12);
    chk("alarm", 16'h0000, psu_link_if_i.alarm_word);
    chk("fault_pin", 0, fault_pin);
    chk("red", 0, red);
    send(3'b001, 8'h00);
    $display("test alarms done");
    chk("in_lamp", 1, in_lamp);
    @(posedge clock_i);
    in_range <= 0;
    cyc_n(4);
    blink(0, n);
    chk("in_blink", 6, n);
    @(posedge clock_i);
    in_pres <= 0;
    cyc_n(4);
    blink(0, n);
    chk("in_dark", 0, n);
    @(posedge clock_i);
    in_pres <= 1;
    in_range <= 1;
    fan_rpm_i[2] <= 16'h1800;
    cyc_n(12);
    chk("fan_wear", 1, wear);
    @(posedge clock_i);
    fitted <= 3'h3;
    cyc_n(6);
    chk("fan_fitted", 0, wear);
    @(posedge clock_i);
    fitted <= 3'h7;
    fan_rpm_i[2] <= 16'h1100;
    cyc_n(12);
    chk("fan_wear", 0, wear);
    send(3'b001, 8'h00);
    $display("test lamps done");
    send(3'b010, 8'h00);
    chk("out_en", 0, out_en);
    cyc_n(12);
    chk("alert", 1, psu_link_if_i.alert_n);
    chk("out_on", 0, st_o[0]);
    send(3'b010, 8'h01);
    chk("out_en", 1, out_en);
    foreach (bytes[i])
    begin
      send(3'b100, bytes[i]);
      chk("reject", 0, rej);
      if (bytes[i][4])
      begin
        chk("oring", 1, oring);
        @(posedge clock_i);
        status_raw_i <= bytes[i][0] ? 16'h0800 : 16'h0040;
        wait_sig(2);
        chk("iso_wait", 1, n < 60);
        chk("iso_pass", !bytes[i][0], iso_pass_o);
        @(posedge clock_i);
        status_raw_i <= 16'h0000;
        cyc_n(12);
        send(3'b001, 8'h00);
      end
    end
    send(3'b100, 8'h02);
    chk("reject", 1, rej);
    @(posedge clock_i);
    capacity_ok_i <= 0;
    send(3'b100, 8'h10);
    chk("reject", 1, rej);
    $display("test commands done");
    @(posedge clock_i);
    mated <= 0;
    cyc_n(6);
    chk("present", 0, psu_link_if_i.present);
    @(posedge clock_i);
    mated <= 1;
    cyc_n(6);
    chk("bus_hold", 1, bus_hold_o);
    chk("addr", {`ADDR_UPPER, 3'b000}, psu_link_if_i.dev_addr);
    chk("alert", 0, psu_link_if_i.alert_n);
    $display("test replug done");
    give_verdict();
  end
endmodule : tb
